// ==== pkg/mdtac_pkg.sv ====
// Shared constants and carrier types for the metering timing/aux config bank.
// Assumes one 20 MHz clock and a word-wide host access port.
package mdtac_pkg;

    // Register offsets (12-bit host address space)
    localparam logic [11:0] ADDR_AUX_CFG   = 12'h010;
    localparam logic [11:0] ADDR_SYSCLK_KHZ   = 12'h012;
    localparam logic [11:0] ADDR_CYC_CNT   = 12'h01c;
    localparam logic [11:0] ADDR_REJ_LVL   = 12'h02c;
    localparam logic [11:0] ADDR_AVG_COEF  = 12'h02e;
    localparam logic [11:0] ADDR_FRAMES    = 12'h040;
    localparam logic [11:0] ADDR_AUX_COUNT = 12'h044;
    localparam logic [11:0] ADDR_HARM_VOLT = 12'h830;
    localparam logic [11:0] ADDR_HARM_CURR = 12'h840;

    // Aux config field positions
    localparam int AUX_SEL_LSB = 0;
    localparam int AUX_SEL_MSB = 2;
    localparam int AUX_ON_BIT  = 6;
    localparam int AUX_HARM_BIT = 7;
    localparam int ORDER_LSB   = 8;
    localparam int ORDER_MSB   = 12;
    localparam logic [15:0] AUX_CFG_WMASK = 16'h1fc7;

    // Reset values
    localparam logic [15:0] RST_AUX_CFG  = 16'h0000;
    localparam logic [15:0] RST_SYSCLK_KHZ  = 16'h1f40;
    localparam logic [15:0] RST_CYC_CNT  = 16'h0010;
    localparam logic [15:0] RST_REJ_LVL  = 16'h00c8;
    localparam logic [15:0] RST_AVG_COEF = 16'h4000;
    localparam logic [31:0] RST_FRAMES   = 32'h03e80000;

    // Fixed point: one scan frame is 1.0 in 16.16
    localparam logic [31:0] ONE_FRAME    = 32'h00010000;
    localparam int          FRAC_BITS    = 16;
    // Rejection level is counted in 1/256 frame steps
    localparam int          REJ_SHIFT    = 8;
    // Square accumulator drops this many low bits when latched as a result
    localparam int          ACC_DROP     = 8;

    // Host request carrier
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } mdtac_host_req_type;

    // Seven converted input samples, index = aux select code
    typedef struct packed {
        logic [7:1][15:0] ch;
    } mdtac_samples_type;

endpackage

// ==== verilog/mdtac_ns_tracker.sv ====
// Line-cycle length tracker: measures frames between zero crossings and
// produces a filtered frames-per-cycle value. Assumes one-cycle tick inputs.
`timescale 1ns/1ps
module mdtac_ns_tracker
    import mdtac_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        frameTick,
    input  wire logic        zeroCross,
    input  wire logic [15:0] rejLevel,
    input  wire logic [15:0] avgCoeff,
    input  wire logic [31:0] nsCurrent,
    output logic             nsLoad,
    output logic      [31:0] nsValue
);

    // Whole tracker state
    typedef struct packed {
        logic        armed;     // A previous crossing exists
        logic [15:0] frameCnt;  // Frames since last crossing
        logic        load;      // Update pulse
        logic [31:0] value;     // Proposed new value
    } mdtac_trk_state_type;

    mdtac_trk_state_type st_r;   // Registered state
    mdtac_trk_state_type st_nxt; // Next state

    logic        [31:0] meas;     // Latest measured length, 16.16
    logic signed [48:0] delta;    // Measurement minus current value
    logic        [48:0] absDelta; // Magnitude of deviation
    logic signed [48:0] prod;     // Coefficient times deviation
    logic signed [48:0] step;     // Scaled averaging step
    logic               reject;   // Cycle too far off to be used

    // Measurement, rejection and averaging
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.load = 1'b0;
        meas        = {st_r.frameCnt, 16'h0000};
        delta       = $signed({17'h00000, meas}) - $signed({17'h00000, nsCurrent});
        absDelta    = delta[48] ? 49'(-delta) : 49'(delta);
        // Zero level turns rejection off entirely
        reject      = (rejLevel != 16'h0000) &&
                      (absDelta > (49'(rejLevel) << REJ_SHIFT));
        prod        = delta * $signed({33'h000000000, avgCoeff});
        step        = prod >>> FRAC_BITS;
        if (frameTick)
        begin
            st_nxt.frameCnt = st_r.frameCnt + 16'h0001;
        end
        if (zeroCross)
        begin
            // A crossing closes one line cycle and opens the next
            st_nxt.frameCnt = frameTick ? 16'h0001 : 16'h0000;
            st_nxt.armed    = 1'b1;
            if (st_r.armed && !reject)
            begin
                st_nxt.load = 1'b1;
                if (avgCoeff == 16'h0000)
                begin
                    st_nxt.value = meas;
                end
                else
                begin
                    st_nxt.value = nsCurrent + step[31:0];
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign nsLoad  = st_r.load;
    assign nsValue = st_r.value;

endmodule // mdtac_ns_tracker

// ==== verilog/mdtac_config_bank.sv ====
// Configuration and timing register bank with aux-channel RMS accumulation
// and line-cycle sequencing.
// Assumes host requests are single-cycle strobes synchronous to clk and that
// sample, frame and zero-crossing ticks come from the converter front end.
//
// Summary of operation
// - Accumulate aux channel squares beside normal processing
// - Aux processing runs only while enable set
// - Harmonic filter applied to aux when enabled
// - Three-bit select picks aux input source
// - Harmonic order field; results at 0x830/0x840
// - System clock kHz register resets 0x1F40
// - Cycle count register resets to 0x10
// - Signal processing cycle end after counted cycles
// - Frames per cycle in 16.16 fixed point
// - Device recomputes frames value from crossings
// - Rejection level decides if odd cycle updates
// - Zero rejection level accepts every cycle
// - Nonzero coefficient averages new measurement in
// - Zero coefficient uses measurement directly
//
// Host map, 12-bit word address
//   0x010 aux config    0x012 clock word
//   0x01c cycle count   0x02c reject level
//   0x02e average coeff 0x040 frames, 16.16
//   0x044 aux sample count (read only)
//   0x830/0x840 voltage/current result (read only)
// Timing
//   Writes land at the taking edge; reads answer one
//   cycle later with a valid pulse, data then holds.
//   The cycle-end pulse follows the closing crossing.
// Limitations
//   Results are sums of squares over 256; the root is
//   left to firmware rather than spent on a divider.
//   A sample on the closing crossing is dropped.
//   The coefficient MSB is not policed here.
`timescale 1ns/1ps
module mdtac_config_bank
    import mdtac_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire mdtac_host_req_type hostReq,
    output logic             [31:0] hostRdata,
    output logic                    hostRdValid,
    input  wire logic               sampleTick,
    input  wire mdtac_samples_type  samples,
    input  wire logic               frameTick,
    input  wire logic               zeroCross,
    input  wire logic        [15:0] harmonicFeedforwardCoeff,
    input  wire logic        [31:0] harmonicFeedbackCoeff,
    output logic                    auxChannelOn,
    output logic                    auxHarmonicFilterOn,
    output logic              [2:0] auxInputSelect,
    output logic              [4:0] harmonicOrder,
    output logic             [15:0] sysclkKhz,
    output logic             [31:0] framesPerDspCycle,
    output logic                    dspCycleDone
);

    // Whole bank state: host registers first, then the
    // line-cycle sequencer, the aux datapath and the read
    // port. One struct keeps the reset and the update of
    // every flop outside the tracker in a single place.
    typedef struct packed {
        logic [15:0] auxCfg;     // Aux channel configuration
        logic [15:0] sysKhz;     // System clock in kHz
        logic [15:0] cycCnt;     // Line cycles per processing cycle
        logic [15:0] rejLvl;     // Line-cycle rejection level
        logic [15:0] avgCoef;    // Line-cycle averaging coefficient
        logic [31:0] frames;     // Frames per processing cycle, 16.16
        logic [15:0] lineCnt;    // Line cycles seen in this cycle
        logic        dspDone;    // End-of-cycle pulse
        logic [39:0] accum;      // Running sum of aux squares
        logic [15:0] sampCnt;    // Aux samples in running sum
        logic [31:0] voltResult; // Last voltage-source result
        logic [31:0] currResult; // Last current-source result
        logic [15:0] auxCount;   // Samples behind the last result
        logic [15:0] harm;       // Harmonic filter output state
        logic [31:0] rdata;      // Read data
        logic        rdValid;    // Read data valid pulse
    } mdtac_bank_state_type;

    mdtac_bank_state_type st_r;   // Registered state
    mdtac_bank_state_type st_nxt; // Next state

    // Helpers; all but nsLoad and nsValue, which the tracker's flops drive,
    // are set on every pass of the datapath process and hold no state
    logic               nsLoad;   // Tracker proposes a new value
    logic        [31:0] nsValue;  // Tracker's proposed value
    logic         [2:0] sel;      // Current aux source code
    logic signed [15:0] rawSamp;  // Selected raw sample
    logic signed [48:0] ffTerm;   // Feed-forward product
    logic signed [48:0] fbTerm;   // Feedback product
    logic signed [48:0] hSum;     // Filter sum before scaling
    logic signed [15:0] procSamp; // Sample after optional filter
    logic signed [31:0] square;   // Square of processed sample
    logic        [15:0] cycLimit; // Effective line-cycle count
    logic               cycEnd;   // This crossing ends the cycle
    logic               selVolt;  // Selected source is a voltage

    // Zero-crossing based frames-per-cycle tracker.
    // It sees the registered frames value, so a host write
    // and a tracker update never race inside the tracker;
    // the bank decides which one lands.
    mdtac_ns_tracker u_tracker
    (
        .clk       (clk),
        .arst_n    (arst_n),
        .frameTick (frameTick),
        .zeroCross (zeroCross),
        .rejLevel  (st_r.rejLvl),
        .avgCoeff  (st_r.avgCoef),
        .nsCurrent (st_r.frames),
        .nsLoad    (nsLoad),
        .nsValue   (nsValue)
    );

    // Aux datapath, sequencing and host access.
    // Order inside the process sets priority: later
    // assignments override earlier ones, so the host
    // write path comes after the tracker update and wins.
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.rdValid = 1'b0;
        st_nxt.dspDone = 1'b0;

        // Source choice; code 000 selects nothing
        // Odd codes are currents, even nonzero codes voltages
        sel     = st_r.auxCfg[AUX_SEL_MSB:AUX_SEL_LSB];
        rawSamp = (sel == 3'h0) ? 16'sh0000 : $signed(samples.ch[sel]);
        selVolt = (sel != 3'h0) && !sel[0];

        // First-order harmonic filter, coefficients scaled by 2^16
        // The square uses the filter state from the last
        // sample, which keeps the multiplier off the path
        // through the new filter output.
        ffTerm   = $signed({33'h000000000, harmonicFeedforwardCoeff}) *
                   $signed({{33{rawSamp[15]}}, rawSamp});
        fbTerm   = $signed({{17{harmonicFeedbackCoeff[31]}}, harmonicFeedbackCoeff}) *
                   $signed({{33{st_r.harm[15]}}, st_r.harm});
        hSum     = ffTerm + fbTerm;
        procSamp = st_r.auxCfg[AUX_HARM_BIT] ? st_r.harm : rawSamp;
        square   = procSamp * procSamp;

        // A zero count would end a cycle on every crossing; treat it as one
        // The compare uses the count as it stands after this crossing
        cycLimit = (st_r.cycCnt == 16'h0000) ? 16'h0001 : st_r.cycCnt;
        cycEnd   = zeroCross && ((st_r.lineCnt + 16'h0001) >= cycLimit);

        // Aux accumulation only while enabled, never touching the cycle count
        // The 40-bit sum holds 1024 full-scale squares before
        // it wraps; long processing cycles need a smaller
        // input swing.
        if (sampleTick && st_r.auxCfg[AUX_ON_BIT])
        begin
            if (st_r.auxCfg[AUX_HARM_BIT])
            begin
                st_nxt.harm = hSum[31:16];
            end
            st_nxt.accum   = st_r.accum + {8'h00, square};
            st_nxt.sampCnt = st_r.sampCnt + 16'h0001;
        end
        else if (!st_r.auxCfg[AUX_ON_BIT])
        begin
            // Disabled channel holds no stale history
            st_nxt.harm    = 16'h0000;
            st_nxt.accum   = 40'h0000000000;
            st_nxt.sampCnt = 16'h0000;
        end

        // Line-cycle counting and processing-cycle end
        // Every crossing counts; a crossing that completes the
        // count restarts it from zero in the same edge.
        if (zeroCross)
        begin
            st_nxt.lineCnt = st_r.lineCnt + 16'h0001;
        end
        if (cycEnd)
        begin
            st_nxt.lineCnt = 16'h0000;
            st_nxt.dspDone = 1'b1;
            if (st_r.auxCfg[AUX_ON_BIT])
            begin
                // Result for the harmonic order in force
                // The source type picks the result slot
                if (selVolt)
                begin
                    st_nxt.voltResult = st_r.accum[39:ACC_DROP];
                end
                else
                begin
                    st_nxt.currResult = st_r.accum[39:ACC_DROP];
                end
                st_nxt.auxCount = st_r.sampCnt;
                st_nxt.accum    = 40'h0000000000;
                st_nxt.sampCnt  = 16'h0000;
            end
        end

        // Tracker updates the frames value
        // A rejected line cycle raises no load at all
        if (nsLoad)
        begin
            st_nxt.frames = nsValue;
        end

        // Host writes; a host write to the frames value wins over the tracker
        // Only the low half of the data word is used by the
        // 16-bit registers; the upper half is ignored.
        if (hostReq.wr)
        begin
            unique case (hostReq.addr)
                ADDR_AUX_CFG:
                begin
                    // Reserved bits never stored
                    st_nxt.auxCfg = hostReq.wdata[15:0] & AUX_CFG_WMASK;
                end
                ADDR_SYSCLK_KHZ:  st_nxt.sysKhz  = hostReq.wdata[15:0];
                ADDR_CYC_CNT:  st_nxt.cycCnt  = hostReq.wdata[15:0];
                ADDR_REJ_LVL:  st_nxt.rejLvl  = hostReq.wdata[15:0];
                // Coefficient MSB is kept clear by the host
                ADDR_AVG_COEF: st_nxt.avgCoef = hostReq.wdata[15:0];
                ADDR_FRAMES:   st_nxt.frames  = hostReq.wdata;
                default:
                begin
                    // Unmapped or read-only address: write ignored
                end
            endcase
        end

        // Host reads answer one cycle later; unmapped reads give zero
        // Read data is taken from the registered state, so a
        // write in the same cycle is seen by the next read.
        if (hostReq.rd)
        begin
            st_nxt.rdValid = 1'b1;
            unique case (hostReq.addr)
                ADDR_AUX_CFG:   st_nxt.rdata = {16'h0000, st_r.auxCfg & AUX_CFG_WMASK};
                ADDR_SYSCLK_KHZ:   st_nxt.rdata = {16'h0000, st_r.sysKhz};
                ADDR_CYC_CNT:   st_nxt.rdata = {16'h0000, st_r.cycCnt};
                ADDR_REJ_LVL:   st_nxt.rdata = {16'h0000, st_r.rejLvl};
                ADDR_AVG_COEF:  st_nxt.rdata = {16'h0000, st_r.avgCoef};
                ADDR_FRAMES:    st_nxt.rdata = st_r.frames;
                ADDR_AUX_COUNT: st_nxt.rdata = {16'h0000, st_r.auxCount};
                ADDR_HARM_VOLT: st_nxt.rdata = st_r.voltResult;
                ADDR_HARM_CURR: st_nxt.rdata = st_r.currResult;
                default:        st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    // State register; reset gives the power-up defaults
    // Everything not named below clears to zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r         <= '0;
            st_r.auxCfg  <= RST_AUX_CFG;
            st_r.sysKhz  <= RST_SYSCLK_KHZ;
            st_r.cycCnt  <= RST_CYC_CNT;
            st_r.rejLvl  <= RST_REJ_LVL;
            st_r.avgCoef <= RST_AVG_COEF;
            st_r.frames  <= RST_FRAMES;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from state flops,
    // so no port carries a combinational path
    assign hostRdata           = st_r.rdata;
    assign hostRdValid         = st_r.rdValid;
    assign auxChannelOn        = st_r.auxCfg[AUX_ON_BIT];
    assign auxHarmonicFilterOn = st_r.auxCfg[AUX_HARM_BIT];
    assign auxInputSelect      = st_r.auxCfg[AUX_SEL_MSB:AUX_SEL_LSB];
    assign harmonicOrder       = st_r.auxCfg[ORDER_MSB:ORDER_LSB];
    assign sysclkKhz           = st_r.sysKhz;
    assign framesPerDspCycle   = st_r.frames;
    assign dspCycleDone        = st_r.dspDone;

endmodule // mdtac_config_bank

// ==== testbench/mdtac_config_bank_props.sv ====
// Concurrent checks on the config bank ports.
// Assumes one clock domain and that registers update at the taking edge.
`timescale 1ns/1ps
module mdtac_config_bank_props
    import mdtac_pkg::*;
(
    input wire logic               clk,
    input wire logic               arst_n,
    input wire mdtac_host_req_type hostReq,
    input wire logic        [31:0] hostRdata,
    input wire logic               hostRdValid,
    input wire logic               zeroCross,
    input wire logic               auxChannelOn,
    input wire logic               auxHarmonicFilterOn,
    input wire logic         [2:0] auxInputSelect,
    input wire logic         [4:0] harmonicOrder,
    input wire logic        [15:0] sysclkKhz,
    input wire logic        [31:0] framesPerDspCycle,
    input wire logic               dspCycleDone
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Aux config write strobe, shared by the field checks
    wire auxWr = hostReq.wr && (hostReq.addr == ADDR_AUX_CFG);

    property p_rd_valid;
        1 |=> hostRdValid == $past(hostReq.rd);
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid late");
    property p_aux_on;
        auxWr |=> auxChannelOn == $past(hostReq.wdata[AUX_ON_BIT]);
    endproperty
    a_aux_on: assert property (p_aux_on) else $error("aux enable wrong");
    property p_aux_harm;
        auxWr |=> auxHarmonicFilterOn == $past(hostReq.wdata[AUX_HARM_BIT]);
    endproperty
    a_aux_harm: assert property (p_aux_harm) else $error("harmonic enable wrong");
    property p_aux_sel;
        auxWr |=> auxInputSelect == $past(hostReq.wdata[2:0]);
    endproperty
    a_aux_sel: assert property (p_aux_sel) else $error("aux select wrong");
    property p_order;
        auxWr |=> harmonicOrder == $past(hostReq.wdata[12:8]);
    endproperty
    a_order: assert property (p_order) else $error("harmonic order wrong");
    property p_reserved;
        hostReq.rd && hostReq.addr == ADDR_AUX_CFG |=> (hostRdata & 32'hffffe038) == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_sysclk_rd;
        hostReq.rd && hostReq.addr == ADDR_SYSCLK_KHZ |=> hostRdata == {16'h0, $past(sysclkKhz)};
    endproperty
    a_sysclk_rd: assert property (p_sysclk_rd) else $error("clock word read wrong");
    property p_frames_wr;
        hostReq.wr && hostReq.addr == ADDR_FRAMES |=> framesPerDspCycle == $past(hostReq.wdata);
    endproperty
    a_frames_wr: assert property (p_frames_wr) else $error("frames write lost");
    // Frames only move on a host write or a tracked line cycle
    property p_frames_cause;
        !$stable(framesPerDspCycle) |-> $past(hostReq.wr) || $past(hostReq.wr, 2)
            || $past(zeroCross, 2) || $past(zeroCross, 3);
    endproperty
    a_frames_cause: assert property (p_frames_cause) else $error("frames moved alone");
    property p_done_cause;
        dspCycleDone |-> $past(zeroCross);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("cycle end w/o crossing");
endmodule // mdtac_config_bank_props

bind mdtac_config_bank mdtac_config_bank_props props (.clk(clk), .arst_n(arst_n),
    .hostReq(hostReq), .hostRdata(hostRdata), .hostRdValid(hostRdValid),
    .zeroCross(zeroCross), .auxChannelOn(auxChannelOn),
    .auxHarmonicFilterOn(auxHarmonicFilterOn), .auxInputSelect(auxInputSelect),
    .harmonicOrder(harmonicOrder), .sysclkKhz(sysclkKhz),
    .framesPerDspCycle(framesPerDspCycle), .dspCycleDone(dspCycleDone));

// ==== testbench/mdtac_host_model.sv ====
// Host controller model: one-cycle register strobes on falling edges.
// Assumes the bank answers a read exactly one cycle after taking it.
`timescale 1ns/1ps
module mdtac_host_model
    import mdtac_pkg::*;
(
    input  wire logic          clk,
    output mdtac_host_req_type hostReq,
    input  wire logic   [31:0] hostRdata,
    input  wire logic          hostRdValid
);
    initial hostReq = '0;
    // Idle lines show inverted values so stale data never looks valid
    task automatic regWrite(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        if (a == ADDR_AVG_COEF) d[15] = 1'b0;
        hostReq = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        hostReq = '{1'b0, 1'b0, ~a, ~d};
    endtask
    // Answer is taken in the cycle after the strobe, where it stands
    task automatic regRead(input logic [11:0] a, output logic [31:0] d, output logic v);
        @(negedge clk);
        hostReq = '{1'b0, 1'b1, a, 32'h0};
        @(negedge clk);
        hostReq = '{1'b0, 1'b0, ~a, 32'hffffffff};
        v = hostRdValid;
        d = hostRdata;
    endtask
endmodule // mdtac_host_model

// ==== testbench/meter_dsp_timing_aux_config_test.sv ====
// Self-checking bench for the config bank; host model drives the port.
// Assumes front-end ticks are driven here on falling edges.
`timescale 1ns/1ps
module meter_dsp_timing_aux_config_test
    import mdtac_pkg::*;
;
    logic               clk = 1'b0, arst_n = 1'b0;
    logic               sampleTick = 1'b0, frameTick = 1'b0, zeroCross = 1'b0;
    mdtac_samples_type  samples = '0;
    mdtac_host_req_type hostReq;
    logic        [31:0] hostRdata, framesPerDspCycle, rd;
    logic               hostRdValid, auxChannelOn, auxHarmonicFilterOn, dspCycleDone, v;
    logic         [2:0] auxInputSelect;
    logic         [4:0] harmonicOrder;
    logic        [15:0] sysclkKhz;
    int                 failCount = 0, samplesChecked = 0;

    mdtac_config_bank uut (.clk(clk), .arst_n(arst_n), .hostReq(hostReq),
        .hostRdata(hostRdata), .hostRdValid(hostRdValid), .sampleTick(sampleTick),
        .samples(samples), .frameTick(frameTick), .zeroCross(zeroCross),
        .harmonicFeedforwardCoeff(16'h0091), .harmonicFeedbackCoeff(32'h00001831),
        .auxChannelOn(auxChannelOn), .auxHarmonicFilterOn(auxHarmonicFilterOn),
        .auxInputSelect(auxInputSelect), .harmonicOrder(harmonicOrder),
        .sysclkKhz(sysclkKhz), .framesPerDspCycle(framesPerDspCycle),
        .dspCycleDone(dspCycleDone));
    mdtac_host_model host (.clk(clk), .hostReq(hostReq), .hostRdata(hostRdata),
        .hostRdValid(hostRdValid));

    always #25 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (seen !== exp)
        begin
            failCount++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic readCheck(input logic [11:0] a, input logic [31:0] exp);
        host.regRead(a, rd, v);
        check({31'h0, v}, 32'h1, "no read answer");
        check(rd, exp, "read data");
    endtask
    // One-cycle pulse; the cycle's registered results are settled on return
    task automatic tick(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask
    task automatic lineCycle(input int n);
        repeat (n) tick(frameTick);
        tick(zeroCross);
        repeat (3) @(negedge clk);
    endtask
    // Crossings until a processing cycle ends; bounded so a stuck count fails
    task automatic syncDone();
        int i;
        for (i = 0; i < 40; i++)
        begin
            tick(zeroCross);
            if (dspCycleDone === 1'b1) break;
        end
        check({31'h0, dspCycleDone}, 32'h1, "cycle end missing");
    endtask

    task automatic t_reset();
        readCheck(ADDR_AUX_CFG, 32'h0);
        readCheck(ADDR_SYSCLK_KHZ, 32'h00001f40);
        readCheck(ADDR_CYC_CNT, 32'h00000010);
        readCheck(ADDR_FRAMES, 32'h03e80000);
        readCheck(12'h7fe, 32'h0);
        host.regWrite(ADDR_SYSCLK_KHZ, 32'h00004e20);
        check({16'h0, sysclkKhz}, 32'h00004e20, "clock word");
        $display("reset values test done");
    endtask
    task automatic t_auxcfg();
        int k;
        host.regWrite(ADDR_AUX_CFG, 32'h0000f5fe);
        readCheck(ADDR_AUX_CFG, 32'h000015c6);
        check({27'h0, harmonicOrder}, 32'd21, "order");
        check({30'h0, auxHarmonicFilterOn, auxChannelOn}, 32'h3, "enables");
        for (k = 1; k < 8; k++)
        begin
            host.regWrite(ADDR_AUX_CFG, k);
            check({29'h0, auxInputSelect}, k, "select");
        end
        $display("aux config test done");
    endtask
    task automatic t_frames();
        host.regWrite(ADDR_FRAMES, 32'h00012345);
        readCheck(ADDR_FRAMES, 32'h00012345);
        check(framesPerDspCycle, 32'h00012345, "frames out");
        $display("frames write test done");
    endtask
    task automatic t_cycle();
        host.regWrite(ADDR_CYC_CNT, 32'h2);
        syncDone();
        tick(zeroCross);
        check({31'h0, dspCycleDone}, 32'h0, "early cycle end");
        repeat (2) @(negedge clk);
        tick(zeroCross);
        check({31'h0, dspCycleDone}, 32'h1, "cycle end");
        @(negedge clk);
        check({31'h0, dspCycleDone}, 32'h0, "cycle end held");
        $display("cycle count test done");
    endtask
    task automatic t_aux();
        samples.ch[2] = 16'h0100;
        host.regWrite(ADDR_AUX_CFG, 32'h00000042);
        syncDone();
        repeat (4) tick(sampleTick);
        syncDone();
        readCheck(ADDR_HARM_VOLT, 32'h00000400);
        readCheck(ADDR_AUX_COUNT, 32'h4);
        samples.ch[3] = 16'h7fff;
        // Disabled samples differ, so any leak changes the result
        samples.ch[2] = 16'h0200;
        host.regWrite(ADDR_AUX_CFG, 32'h00000002);
        repeat (4) tick(sampleTick);
        syncDone();
        readCheck(ADDR_HARM_VOLT, 32'h00000400);
        // Filtered current source: states 0, 72, 79 are squared
        host.regWrite(ADDR_AUX_CFG, 32'h000000c3);
        repeat (3) tick(sampleTick);
        syncDone();
        readCheck(ADDR_HARM_CURR, 32'h0000002c);
        readCheck(ADDR_AUX_COUNT, 32'h3);
        $display("aux channel test done");
    endtask
    task automatic t_track();
        host.regWrite(ADDR_REJ_LVL, 32'h0);
        host.regWrite(ADDR_AVG_COEF, 32'h0);
        lineCycle(0);
        lineCycle(10);
        readCheck(ADDR_FRAMES, 10 * ONE_FRAME);
        host.regWrite(ADDR_AVG_COEF, 32'h00004000);
        lineCycle(18);
        readCheck(ADDR_FRAMES, 32'h000c0000);
        host.regWrite(ADDR_AVG_COEF, 32'h0);
        host.regWrite(ADDR_REJ_LVL, 32'h00000300);
        lineCycle(30);
        readCheck(ADDR_FRAMES, 32'h000c0000);
        lineCycle(14);
        readCheck(ADDR_FRAMES, 32'h000e0000);
        $display("frames tracker test done");
    endtask

    task automatic finishTest();
        $display("comparisons %0d mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog: 20000 cycles, far beyond the few hundred cycles the tests need
    initial
    begin
        #(50 * 20000);
        failCount++;
        finishTest();
    end
    initial
    begin
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_auxcfg();
        t_frames();
        t_cycle();
        t_aux();
        t_track();
        finishTest();
    end
endmodule // meter_dsp_timing_aux_config_test
